// file: logic/chan_timer.sv
// Four-channel 8-bit down-counter/timer with daisy-chain vectored interrupts
//
// What this block does
// RULE1 - Four independent channels, own control and counter
// RULE2 - Timer mode prescales system clock by 16/256
// RULE3 - Control bit five picks prescale factor
// RULE4 - Eight-bit reload value, zero means 256
// RULE5 - Reload counter at start and every zero
// RULE6 - Counter mode steps once per trigger edge
// RULE7 - Trigger input synchronised before counting
// RULE8 - Timer starts on reload write or trigger
// RULE9 - Zero pulse outputs on channels 0-2 only
// RULE10 - Interrupt requested only when channel enabled
// RULE11 - Interrupt enable set per channel
// RULE12 - Acknowledge on fetch plus I/O, drive vector
// RULE13 - Channel 0 highest, channel 3 lowest priority
// RULE14 - Claim priority only while chain input high
// RULE15 - Pending request pulls chain output low
// RULE16 - Pending or in service holds chain low
// RULE17 - Return prefix byte raises chain one fetch
// RULE18 - Control word decoded into seven settings
// RULE19 - Host reads live counter value
// RULE20 - Bit0 marks control; bit2 means reload follows
// RULE21 - Vector to channel 0 with channel in bits 2:1
// RULE22 - Two-bit select addresses channels 0-3
// RULE23 - Zero pulse high for one clock
// RULE24 - Reset stops all, disables interrupts
`timescale 1ns/1ns
module chan_timer
	import chan_timer_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	input  wire logic                    chip_select_n,
	input  wire logic                    io_request_n,
	input  wire logic                    read_n,
	input  wire logic                    opcode_fetch_n,
	input  wire logic                    channel_select_hi,
	input  wire logic                    channel_select_lo,
	input  wire logic [7:0]              data_in,
	output logic      [7:0]              data_out,
	output logic                         data_oe,
	input  wire logic [NUM_CHANNELS-1:0] count_trigger_in,
	output logic      [2:0]              zero_count_pulse_out,
	output logic                         irq_n,
	input  wire logic                    priority_chain_in,
	output logic                         priority_chain_out
);
	localparam int N = NUM_CHANNELS;

	// Trigger pins come from outside: two flops before any use
	logic [N-1:0] trg_meta_q;
	logic [N-1:0] trg_sync_q;
	logic [N-1:0] trg_prev_q;
	// Host strobes are sampled the same way
	logic [2:0]   bus_meta_q;
	logic [2:0]   bus_sync_q;
	logic [2:0]   bus_prev_q;
	logic [7:0]   din_meta_q;
	logic [7:0]   din_q;
	logic [1:0]   sel_meta_q;
	logic [1:0]   sel_q;
	logic         rdn_meta_q;
	logic         rdn_q;

	logic [7:0]   ctrl_q   [N];
	logic [7:0]   reload_q [N];
	logic [7:0]   count_q  [N];
	logic [7:0]   presc_q  [N];
	ch_state_t    state_q  [N];
	logic [N-1:0] tc_next_q;
	logic [N-1:0] pend_q;
	logic [N-1:0] serv_q;
	logic [4:0]   vector_q;
	logic [2:0]   zc_q;
	logic         prefix_q;
	logic         return_from_irq_instr_win_q;
	logic         chain_open_q;
	logic [7:0]   data_out_q;
	logic         data_oe_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			trg_meta_q <= '0;
			trg_sync_q <= '0;
			trg_prev_q <= '0;
			bus_meta_q <= 3'h7;
			bus_sync_q <= 3'h7;
			bus_prev_q <= 3'h7;
		end else begin
			trg_meta_q <= count_trigger_in; // RULE7
			trg_sync_q <= trg_meta_q;
			trg_prev_q <= trg_sync_q;
			bus_meta_q <= {chip_select_n, io_request_n, opcode_fetch_n};
			bus_sync_q <= bus_meta_q;
			bus_prev_q <= bus_sync_q;
		end
	end

	// Data, select and direction are pins too, so they take the same two
	// flops as the strobes. The rise detect adds no edge to the strobes, so these
	// reach the decode in the same clock as a strobe that changed with them.
	// Limitation: the host must hold them stable across the whole strobe.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			din_meta_q <= 8'h00;
			din_q      <= 8'h00;
			sel_meta_q <= 2'h0;
			sel_q      <= 2'h0;
			rdn_meta_q <= 1'b1;
			rdn_q      <= 1'b1;
		end else begin
			din_meta_q <= data_in;
			din_q      <= din_meta_q;
			sel_meta_q <= {channel_select_hi, channel_select_lo}; // RULE22
			sel_q      <= sel_meta_q;
			rdn_meta_q <= read_n;
			rdn_q      <= rdn_meta_q;
		end
	end

	// Strobe edges are taken after the synchronisers: three clocks of
	// latency per access, traded for a decode free of metastability.
	wire cs_s    = ~bus_sync_q[2];
	wire io_request_n_s  = ~bus_sync_q[1];
	wire m1_s    = ~bus_sync_q[0];
	wire io_request_n_rise = io_request_n_s & bus_prev_q[1];
	wire m1_rise   = m1_s & bus_prev_q[0];
	wire acc_go  = io_request_n_rise & cs_s & ~m1_s;
	wire wr_go   = acc_go & rdn_q;
	wire rd_go   = acc_go & ~rdn_q;
	wire ack_go  = io_request_n_rise & m1_s; // RULE12
	wire fetch_go = m1_rise & ~io_request_n_s;
	// Open for the whole fetch that follows the return prefix byte
	wire chain_open = m1_s & (fetch_go ? prefix_q : chain_open_q); // RULE17

	wire [N-1:0] trg_edge_pos = trg_sync_q & ~trg_prev_q;
	wire [N-1:0] trg_edge_neg = ~trg_sync_q & trg_prev_q;

	// Highest-priority channel: lowest index wins
	function automatic logic [N:0] first_set(input logic [N-1:0] v);
		logic [N:0] r;
		r = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, N'(1) << i};
			end
		end
		return r;
	endfunction : first_set

	function automatic logic [1:0] idx_of(input logic [N-1:0] onehot);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 0; i < N; i++) begin
			if (onehot[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction : idx_of

	// Unserviced pending requests rank below a channel in service of higher or equal rank; any channel in service blocks the grant
	wire [N:0]   serv_sel = first_set(serv_q);
	wire [N:0]   pend_sel = first_set(pend_q);
	wire         pend_blocked = serv_sel[N] & (idx_of(serv_sel[N-1:0]) <= idx_of(pend_sel[N-1:0]));
	wire         grant_ok = priority_chain_in & pend_sel[N] & ~serv_sel[N]; // RULE14
	wire [1:0]   grant_ch = idx_of(pend_sel[N-1:0]); // RULE13

	logic [N-1:0] zero_hit;
	logic [N-1:0] ctrl_wr;
	logic [N-1:0] tc_wr;
	// A reload byte for channel 0 may have bit 0 clear; it must not land here
	wire          vec_wr = wr_go & (sel_q == 2'h0) & ~tc_next_q[0] & ~din_q[CTRL_WORD_BIT]; // RULE21

	always_comb begin
		for (int i = 0; i < N; i++) begin
			ctrl_wr[i] = wr_go & (sel_q == 2'(i)) & ~tc_next_q[i] & din_q[CTRL_WORD_BIT]; // RULE20
			tc_wr[i]   = wr_go & (sel_q == 2'(i)) & tc_next_q[i];
		end
	end

	// Each channel: prescaler, down-counter and start control.
	// The prescaler is held at zero outside the running state, so every
	// period starts on a clean boundary.
	for (genvar g = 0; g < N; g++) begin : g_ch // RULE1
		wire        timer_mode = ~ctrl_q[g][CTRL_MODE_BIT]; // RULE18
		wire        edge_hit = ctrl_q[g][CTRL_EDGE_BIT] ? trg_edge_pos[g] : trg_edge_neg[g];
		wire [7:0]  presc_max = ctrl_q[g][CTRL_PRESC_BIT] ? PRESC_LONG_MAX : PRESC_SHORT_MAX; // RULE3
		wire        presc_tick = (presc_q[g] == presc_max); // RULE2
		wire        step = (state_q[g] == CH_RUNNING) & (timer_mode ? presc_tick : edge_hit); // RULE6
		assign zero_hit[g] = step & (count_q[g] == 8'h01);
		wire        sw_stop = ctrl_wr[g] & din_q[CTRL_SWRST_BIT];

		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n) begin
				ctrl_q[g]    <= CTRL_RESET; // RULE24
				reload_q[g]  <= RELOAD_RESET;
				count_q[g]   <= 8'h00;
				presc_q[g]   <= 8'h00;
				state_q[g]   <= CH_STOPPED;
				tc_next_q[g] <= 1'b0;
			end else begin
				if (ctrl_wr[g]) begin
					ctrl_q[g]    <= din_q; // RULE11
					tc_next_q[g] <= din_q[CTRL_TCF_BIT];
				end else if (tc_wr[g]) begin
					reload_q[g]  <= din_q; // RULE4
					tc_next_q[g] <= 1'b0;
				end
				// Counts 0 to max, so one tick every 16 or 256 clocks
				presc_q[g] <= (state_q[g] != CH_RUNNING || presc_tick) ? 8'h00 : presc_q[g] + 8'h01;
				// A reload written while running is kept for the next zero,
				// so the period in progress is never disturbed.
				if (sw_stop) begin
					state_q[g] <= CH_STOPPED;
				end else if (tc_wr[g] && state_q[g] != CH_RUNNING) begin
					count_q[g] <= din_q; // RULE5
					// Counter, or timer with auto start, runs at once; else wait for a trigger
					state_q[g] <= (timer_mode && !ctrl_q[g][CTRL_TRIG_BIT]) || !timer_mode
						? CH_RUNNING : CH_ARMED; // RULE8
				end else if (state_q[g] == CH_ARMED && edge_hit) begin
					state_q[g] <= CH_RUNNING; // RULE8
				end else if (zero_hit[g]) begin
					count_q[g] <= reload_q[g]; // RULE5
				end else if (step) begin
					count_q[g] <= count_q[g] - 8'h01; // RULE4
				end
			end
		end
	end

	// Interrupt pending and in-service flags, vector register.
	// A control word with the enable off drops a request that software
	// no longer wants serviced.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_q     <= '0;
			serv_q     <= '0;
			vector_q   <= VECTOR_RESET[7:3];
			zc_q       <= 3'h0;
			prefix_q   <= 1'b0;
			return_from_irq_instr_win_q <= 1'b0;
			chain_open_q <= 1'b0;
		end else begin
			for (int i = 0; i < N; i++) begin
				// A new zero count wins over the acknowledge that clears it
				if (zero_hit[i] && ctrl_q[i][CTRL_IE_BIT]) begin
					pend_q[i] <= 1'b1; // RULE10
				end else if (ack_go && grant_ok && grant_ch == 2'(i)) begin
					pend_q[i] <= 1'b0;
				end else if (ctrl_wr[i] && !din_q[CTRL_IE_BIT]) begin
					pend_q[i] <= 1'b0; // RULE11
				end
				if (ack_go && grant_ok && grant_ch == 2'(i)) begin
					serv_q[i] <= 1'b1;
				end else if (fetch_go && return_from_irq_instr_win_q && serv_sel[N] && serv_sel[i]) begin
					serv_q[i] <= 1'b0;
				end
			end
			if (vec_wr) begin
				vector_q <= din_q[7:3];
			end
			// Channel 3 has no pin; its zero only feeds the interrupt logic
			zc_q <= zero_hit[2:0]; // RULE23
			if (fetch_go) begin
				prefix_q <= (din_q == RETURN_FROM_IRQ_INSTR_FIRST_BYTE); // RULE17
				return_from_irq_instr_win_q <= prefix_q & (din_q == ACK_OPCODE);
			end
			// Held until the fetch strobe goes away again
			if (fetch_go) begin
				chain_open_q <= prefix_q; // RULE17
			end else if (!m1_s) begin
				chain_open_q <= 1'b0;
			end
		end
	end

	// Bus read and acknowledge drive.
	// Read data is captured once at the strobe, so a count that moves
	// during the strobe cannot tear the byte on the bus.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out_q <= 8'h00;
			data_oe_q  <= 1'b0;
		end else if (rd_go) begin
			data_out_q <= count_q[sel_q]; // RULE19
			data_oe_q  <= 1'b1;
		end else if (ack_go && grant_ok) begin
			data_out_q <= {vector_q, grant_ch, 1'b0}; // RULE12
			data_oe_q  <= 1'b1;
		end else if (!io_request_n_s) begin
			data_oe_q  <= 1'b0;
		end
	end

	assign data_out             = data_out_q;
	assign data_oe              = data_oe_q;
	assign zero_count_pulse_out = zc_q; // RULE9
	// Masked while a channel of higher or equal rank is in service; lower
	// channels wait until the return sequence ends that service.
	assign irq_n                = ~(priority_chain_in & (|pend_q) & ~pend_blocked); // RULE10
	// Chain opens for one fetch after the return prefix when a request waits and none is in service
	assign priority_chain_out   = priority_chain_in
		& ((~(|pend_q) & ~(|serv_q)) | (chain_open & ~(|serv_q))); // RULE15 RULE16 RULE17
endmodule : chan_timer

// file: pkg/chan_timer_pkg.sv
// Constants and types for the four-channel counter/timer
package chan_timer_pkg;
	localparam int          NUM_CHANNELS    = 4;
	localparam int          CTRL_IE_BIT     = 7;
	localparam int          CTRL_MODE_BIT   = 6;
	localparam int          CTRL_PRESC_BIT  = 5;
	localparam int          CTRL_EDGE_BIT   = 4;
	localparam int          CTRL_TRIG_BIT   = 3;
	localparam int          CTRL_TCF_BIT    = 2;
	localparam int          CTRL_SWRST_BIT  = 1;
	localparam int          CTRL_WORD_BIT   = 0;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [7:0]  RELOAD_RESET    = 8'h00;
	localparam logic [7:0]  VECTOR_RESET    = 8'h00;
	localparam logic [7:0]  PRESC_SHORT_MAX = 8'h0f;
	localparam logic [7:0]  PRESC_LONG_MAX  = 8'hff;
	localparam logic [7:0]  RETURN_FROM_IRQ_INSTR_FIRST_BYTE = 8'hed;
	localparam logic [7:0]  ACK_OPCODE      = 8'h4d;
	typedef enum logic [1:0] {CH_STOPPED, CH_ARMED, CH_RUNNING} ch_state_t;
endpackage : chan_timer_pkg

// file: tb/chan_timer_props.sv
// Port-level assertions for the four-channel counter/timer
`timescale 1ns/1ns
module chan_timer_props (
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic       chip_select_n,
	input wire logic       io_request_n,
	input wire logic       read_n,
	input wire logic       opcode_fetch_n,
	input wire logic       channel_select_hi,
	input wire logic       channel_select_lo,
	input wire logic       data_oe,
	input wire logic       irq_n,
	input wire logic       priority_chain_in,
	input wire logic       priority_chain_out,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic [3:0] count_trigger_in,
	input wire logic [2:0] zero_count_pulse_out
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	a_pulse_one: assert property (
		(zero_count_pulse_out & $past(zero_count_pulse_out)) == 3'h0)
		else $error("zero pulse wider than one clock");
	a_chain_in_low: assert property (!priority_chain_in |-> !priority_chain_out)
		else $error("chain out high while chain in low");
	a_request_blocks: assert property ($fell(irq_n) |-> !priority_chain_out)
		else $error("request raised with chain out high");
	a_read_strobe: assert property (
		$rose(data_oe) |-> !io_request_n && $past(io_request_n, 2) == 1'b0)
		else $error("bus driven without a held strobe");
	a_oe_release: assert property (io_request_n [*4] |-> !data_oe)
		else $error("bus still driven after strobe release");
	a_oe_not_write: assert property (
		$rose(data_oe) |-> read_n == 1'b0 || opcode_fetch_n == 1'b0)
		else $error("bus driven during a write");
	a_vector_bit0: assert property (
		$rose(data_oe) && !opcode_fetch_n |-> data_out[0] == 1'b0)
		else $error("vector bit zero set");
	a_reset_quiet: assert property ($rose(arst_n) |-> irq_n && !data_oe &&
		zero_count_pulse_out == 3'h0 && priority_chain_out == priority_chain_in)
		else $error("outputs active after reset");
endmodule : chan_timer_props

bind chan_timer chan_timer_props props_i (.*);

// file: tb/chan_timer_tb.sv
// Self-checking bench for the four-channel counter/timer
`timescale 1ns/1ns
module chan_timer_tb;
	logic       core_clk, arst_n, chip_select_n, io_request_n, read_n, opcode_fetch_n;
	logic       channel_select_hi, channel_select_lo, data_oe, irq_n;
	logic       priority_chain_in, priority_chain_out, seen;
	logic [7:0] data_in, data_out, q;
	logic [3:0] count_trigger_in;
	logic [2:0] zero_count_pulse_out;
	int         errors, cmp_count, n;
	int         open_cnt = 0;
	int         mark;
	int         zc_cnt[3] = '{0, 0, 0};
	chan_timer uut (.*);
	host_bus_model host (.*);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		for (int i = 0; i < 3; i++) zc_cnt[i] <= zc_cnt[i] + zero_count_pulse_out[i];
	// Clocks with the chain output high, to measure how long it opens
	always @(posedge core_clk)
		open_cnt <= open_cnt + ((priority_chain_out === 1'b1) ? 1 : 0);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [1:0] ch, input logic [7:0] d);
		host.cycle(1'b0, 1'b1, 1'b0, ch, d, q, seen);
	endtask : wr
	task automatic rd(input logic [1:0] ch, input logic [7:0] exp);
		host.cycle(1'b0, 1'b1, 1'b1, ch, 8'h00, q, seen);
		chk({seen, q}, {1'b1, exp});
	endtask : rd
	task automatic trig(input int c);
		@(posedge core_clk);
		count_trigger_in[c] <= 1'b1;
		repeat (4) @(posedge core_clk);
		count_trigger_in[c] <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : trig
	task automatic wait_pulse(input logic [1:0] ch);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (zero_count_pulse_out[ch] !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			errors++;
			finish_test();
		end
	endtask : wait_pulse
	task automatic t_counter();
		for (int c = 0; c < 4; c++) begin
			wr(c[1:0], 8'h57);
			wr(c[1:0], 8'h02);
			rd(c[1:0], 8'h02);
			trig(c);
			rd(c[1:0], 8'h01);
			trig(c);
			rd(c[1:0], 8'h02);
			wr(c[1:0], 8'h03);
		end
		for (int i = 0; i < 3; i++) chk(16'(zc_cnt[i]), 16'h0001);
	endtask : t_counter
	task automatic t_period(input logic [1:0] ch, input logic [7:0] ctl, tc, input int exp);
		wr(ch, ctl);
		wr(ch, tc);
		wait_pulse(ch);
		wait_pulse(ch);
		chk(16'(n), 16'(exp));
		wr(ch, 8'h03);
	endtask : t_period
	// Trigger-started timer, falling edge: idle until the edge, then 16 x 4
	task automatic t_trig_start();
		wr(2'h0, 8'h0f);
		wr(2'h0, 8'h04);
		repeat (100) @(posedge core_clk);
		rd(2'h0, 8'h04);
		trig(0);
		wait_pulse(2'h0);
		wait_pulse(2'h0);
		chk(16'(n), 16'h0040);
		wr(2'h0, 8'h03);
	endtask : t_trig_start
	task automatic t_irq();
		wr(2'h0, 8'ha8);
		wr(2'h1, 8'h87);
		wr(2'h1, 8'h10);
		for (n = 0; irq_n !== 1'b0 && n < 400; n++) @(posedge core_clk);
		if (n >= 400) begin
			errors++;
			finish_test();
		end
		chk(priority_chain_out, 1'b0);
		mark = open_cnt;
		host.cycle(1'b1, 1'b0, 1'b1, 2'h0, 8'hed, q, seen);
		chk(16'(open_cnt - mark), 16'h0000);
		mark = open_cnt;
		host.cycle(1'b1, 1'b0, 1'b1, 2'h0, 8'h00, q, seen);
		chk(16'(open_cnt - mark), 16'h0008);
		chk(priority_chain_out, 1'b0);
		priority_chain_in <= 1'b0;
		host.cycle(1'b1, 1'b1, 1'b1, 2'h0, 8'h00, q, seen);
		chk(seen, 1'b0);
		priority_chain_in <= 1'b1;
		host.cycle(1'b1, 1'b1, 1'b1, 2'h0, 8'h00, q, seen);
		chk({seen, q}, 9'h1aa);
		wr(2'h1, 8'h03);
		chk({irq_n, priority_chain_out}, 2'b10);
		host.cycle(1'b1, 1'b0, 1'b1, 2'h0, 8'hed, q, seen);
		host.cycle(1'b1, 1'b0, 1'b1, 2'h0, 8'h4d, q, seen);
		host.cycle(1'b1, 1'b0, 1'b1, 2'h0, 8'h00, q, seen);
		chk(priority_chain_out, 1'b1);
	endtask : t_irq
	initial begin
		arst_n = 1'b0;
		count_trigger_in = 4'h0;
		priority_chain_in = 1'b1;
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		chk({irq_n, data_oe, zero_count_pulse_out, priority_chain_out}, 6'h21);
		t_counter();
		t_period(2'h0, 8'h07, 8'h00, 4096);
		t_period(2'h2, 8'h27, 8'h01, 256);
		t_trig_start();
		t_irq();
		finish_test();
	end
endmodule : chan_timer_tb

// file: tb/host_bus_model.sv
// Host processor bus model: I/O cycles, acknowledge and opcode fetches
`timescale 1ns/1ns
module host_bus_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	output logic            chip_select_n,
	output logic            io_request_n,
	output logic            read_n,
	output logic            opcode_fetch_n,
	output logic            channel_select_hi,
	output logic            channel_select_lo,
	output logic [7:0]      data_in
);
	initial begin
		{chip_select_n, io_request_n, read_n, opcode_fetch_n} = 4'hf;
		{channel_select_hi, channel_select_lo, data_in} = 10'h000;
	end
	// Select and data settle two clocks ahead of the strobe and hold until it rises
	task automatic cycle(input logic f, io, rd, input logic [1:0] ch, input logic [7:0] wd,
		output logic [7:0] q, output logic seen);
		seen = 1'b0;
		q = 8'h00;
		@(posedge core_clk);
		chip_select_n <= f;
		{channel_select_hi, channel_select_lo} <= ch;
		read_n <= ~rd;
		data_in <= wd;
		repeat (2) @(posedge core_clk);
		opcode_fetch_n <= ~f;
		io_request_n <= ~io;
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			if (data_oe === 1'b1 && !seen) begin
				seen = 1'b1;
				q = data_out;
			end
		end
		{opcode_fetch_n, io_request_n} <= 2'h3;
		repeat (4) @(posedge core_clk);
		chip_select_n <= 1'b1;
		// Released bus must not look like the last value
		data_in <= ~wd;
	endtask : cycle
endmodule : host_bus_model
